// ==== rtl/emp_defines.svh ====
`ifndef EMP_DEFINES_SVH
`define EMP_DEFINES_SVH

// Register addresses on the core's register port
`define EMP_PAGE_ADDR      8'hAA
`define EMP_CFG_ADDR       8'hAB

// Reset values
`define EMP_PAGE_RESET     5'h00
`define EMP_MODE_RESET     2'h0
`define EMP_ALEW_RESET     2'h3

// Field positions
`define EMP_PAGE_MSB       4
`define EMP_MODE_LSB       2
`define EMP_ALEW_LSB       0

// On-chip space: 4096 bytes, wraps on twelve address bits
`define EMP_ONCHIP_MASK    16'h0FFF
`define EMP_ONCHIP_TOP     16'h1000

`endif

// ==== rtl/emp_pkg.sv ====
package emp_pkg;

  // Operating mode field encodings
  typedef enum logic [1:0] {
    EMP_MODE_INTERNAL = 2'h0,
    EMP_MODE_SPLIT_NB = 2'h1,
    EMP_MODE_SPLIT_BS = 2'h2,
    EMP_MODE_EXTERNAL = 2'h3
  } emp_mode_t;

  // One external-data move request from the core
  typedef struct packed {
    logic        is8;      // 8-bit indirect form
    logic        write;    // Write, else read
    logic [7:0]  lowAddr;  // Index register value
    logic [15:0] dptr;     // 16-bit pointer value
  } emp_req_t;

  // Routing decided for one move
  typedef struct packed {
    logic        external; // Off-chip target
    logic        hiDrive;  // Upper four address lines driven
    logic [15:0] addr;     // Address seen by the target memory
  } emp_route_t;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    EMP_XF_IDLE   = 3'b001,
    EMP_XF_ONCHIP = 3'b010,
    EMP_XF_OFFCHP = 3'b100
  } emp_xfer_t;

  // Latch enable sequencer states
  typedef enum logic [2:0] {
    EMP_ALE_IDLE = 3'b001,
    EMP_ALE_HIGH = 3'b010,
    EMP_ALE_LOW  = 3'b100
  } emp_ale_t;

endpackage

// ==== rtl/emp_ale_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module emp_ale_gen
  import emp_pkg::*;
(
  input  wire logic       sys_clk, // System clock
  input  wire logic       srst,    // Synchronous reset
  input  wire logic       start,   // Begin a latch pulse
  input  wire logic [1:0] width,   // Width field, sampled at start
  output logic            ale,     // Address latch enable
  output logic            done     // High in the last low cycle
);

  emp_ale_t   state;
  logic [1:0] cnt;
  logic [1:0] widthHold;

  // Flags the last low cycle so the move can end right after the low phase
  assign done = (state == EMP_ALE_LOW) && (cnt == 2'h0);

  // High and low phases each last width plus one cycles
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state     <= EMP_ALE_IDLE;
      cnt       <= 2'h0;
      widthHold <= 2'h0;
      ale       <= 1'b0;
    end else begin
      unique case (state)
        EMP_ALE_IDLE: begin
          if (start) begin
            widthHold <= width; // Held so a register write mid-pulse has no effect
            cnt       <= width;
            ale       <= 1'b1;
            state     <= EMP_ALE_HIGH;
          end
        end
        EMP_ALE_HIGH: begin
          if (cnt == 2'h0) begin
            ale   <= 1'b0;
            cnt   <= widthHold;
            state <= EMP_ALE_LOW;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        EMP_ALE_LOW: begin
          if (cnt == 2'h0) begin
            state <= EMP_ALE_IDLE;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/emp_page_config.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emp_defines.svh"

module emp_page_config
  import emp_pkg::*;
(
  input  wire logic        sys_clk,   // System clock, 20 MHz
  input  wire logic        srst,      // Synchronous reset, active high
  input  wire logic        sfrWrEn,   // Register write strobe
  input  wire logic        sfrRdEn,   // Register read strobe
  input  wire logic [7:0]  sfrAddr,   // Register address
  input  wire logic [7:0]  sfrWrData, // Register write data
  output logic      [7:0]  sfrRdData, // Register read data
  input  wire logic        movxStart, // Move request pulse
  input  wire emp_req_t    movxReq,   // Move request fields
  output logic             busy,      // Move in progress
  output logic             movxDone,  // Move finished pulse
  output logic             memExt,    // Target is off-chip
  output logic             memWrite,  // Latched direction
  output logic      [15:0] effAddr,   // Address at the target memory
  output logic      [3:0]  addrHi,    // Upper address lines A11..A8
  output logic             addrHiOe,  // High while A11..A8 are driven
  output logic      [7:0]  addrLo,    // Lower address lines
  output logic             ale        // Address latch enable
);

  logic [4:0] page;
  emp_mode_t  mode;
  logic [1:0] aleWidth;
  emp_mode_t  curMode;
  logic [1:0] curWidth;
  emp_xfer_t  xstate;
  emp_route_t route;
  logic       accept;
  logic       aleDone;

  // Routing of one move from the current register contents
  function automatic emp_route_t decode(emp_mode_t m, logic [4:0] pg, emp_req_t rq);
    emp_route_t r;
    logic       split;
    r     = '0;
    split = (m == EMP_MODE_SPLIT_NB) || (m == EMP_MODE_SPLIT_BS);
    if (rq.is8) begin
      unique case (m)
        EMP_MODE_INTERNAL: begin
          r.addr = {3'h0, pg, rq.lowAddr} & `EMP_ONCHIP_MASK;
        end
        EMP_MODE_SPLIT_NB, EMP_MODE_SPLIT_BS: begin
          r.external = pg[`EMP_PAGE_MSB];
          r.addr     = {4'h0, pg[3:0], rq.lowAddr};
          r.hiDrive  = pg[`EMP_PAGE_MSB] && (m == EMP_MODE_SPLIT_BS);
        end
        EMP_MODE_EXTERNAL: begin
          r.external = 1'b1;
          r.addr     = {8'h00, rq.lowAddr};
        end
      endcase
    end else begin
      r.external = (m == EMP_MODE_EXTERNAL) || (split && rq.dptr >= `EMP_ONCHIP_TOP);
      r.addr     = r.external ? rq.dptr : (rq.dptr & `EMP_ONCHIP_MASK);
      r.hiDrive  = r.external;
    end
    return r;
  endfunction

  assign accept = movxStart && (xstate == EMP_XF_IDLE);
  assign route  = decode(mode, page, movxReq);

  // Register writes; only the defined fields are stored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      page     <= `EMP_PAGE_RESET;
      mode     <= emp_mode_t'(`EMP_MODE_RESET);
      aleWidth <= `EMP_ALEW_RESET;
    end else if (sfrWrEn) begin
      if (sfrAddr == `EMP_PAGE_ADDR) begin
        page <= sfrWrData[4:0];
      end
      if (sfrAddr == `EMP_CFG_ADDR) begin
        mode     <= emp_mode_t'(sfrWrData[`EMP_MODE_LSB +: 2]);
        aleWidth <= sfrWrData[`EMP_ALEW_LSB +: 2];
      end
    end
  end

  // Registered read; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sfrRdData <= 8'h00;
    end else if (sfrRdEn) begin
      unique case (sfrAddr)
        `EMP_PAGE_ADDR: sfrRdData <= {3'h0, page};
        `EMP_CFG_ADDR:  sfrRdData <= {4'h0, mode, aleWidth};
        default:        sfrRdData <= 8'h00;
      endcase
    end
  end

  // Transfer sequencer; settings are frozen at acceptance
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      xstate   <= EMP_XF_IDLE;
      busy     <= 1'b0;
      movxDone <= 1'b0;
      memExt   <= 1'b0;
      memWrite <= 1'b0;
      effAddr  <= 16'h0000;
      addrHi   <= 4'h0;
      addrHiOe <= 1'b0;
      addrLo   <= 8'h00;
      curMode  <= EMP_MODE_INTERNAL;
      curWidth <= 2'h0;
    end else begin
      movxDone <= 1'b0;
      unique case (xstate)
        EMP_XF_IDLE: begin
          if (accept) begin
            curMode  <= mode;
            curWidth <= aleWidth;
            memExt   <= route.external;
            memWrite <= movxReq.write;
            effAddr  <= route.addr;
            addrHi   <= route.hiDrive ? route.addr[11:8] : 4'h0;
            addrHiOe <= route.hiDrive;
            addrLo   <= route.addr[7:0];
            busy     <= 1'b1;
            xstate   <= route.external ? EMP_XF_OFFCHP : EMP_XF_ONCHIP;
          end
        end
        EMP_XF_ONCHIP: begin
          busy     <= 1'b0;
          movxDone <= 1'b1;
          xstate   <= EMP_XF_IDLE;
        end
        EMP_XF_OFFCHP: begin
          if (aleDone) begin
            busy     <= 1'b0;
            movxDone <= 1'b1;
            addrHiOe <= 1'b0;
            xstate   <= EMP_XF_IDLE;
          end
        end
      endcase
    end
  end

  // Latch enable pulse for off-chip moves
  emp_ale_gen u_ale (
    .sys_clk (sys_clk),
    .srst    (srst),
    .start   (accept && route.external),
    .width   (aleWidth),
    .ale     (ale),
    .done    (aleDone)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic acc8;
  logic splitNow;
  assign acc8     = accept && movxReq.is8;
  assign splitNow = (mode == EMP_MODE_SPLIT_NB) || (mode == EMP_MODE_SPLIT_BS);

  chk_page_readzero: assert property (
    sfrRdEn && sfrAddr == `EMP_PAGE_ADDR |=> sfrRdData[7:5] == 3'h0 && sfrRdData[4:0] == $past(page))
    else $error("page register upper bits not zero");

  chk_cfg_readzero: assert property (
    sfrRdEn && sfrAddr == `EMP_CFG_ADDR |=> sfrRdData[7:4] == 4'h0)
    else $error("config register upper bits not zero");

  chk_int_onchip: assert property (
    accept && mode == EMP_MODE_INTERNAL |=> !memExt && effAddr < `EMP_ONCHIP_TOP && !ale)
    else $error("internal mode move left the chip");

  chk_page_onchip: assert property (
    acc8 && mode == EMP_MODE_INTERNAL
    |=> effAddr[11:8] == $past(page[3:0]) && effAddr[7:0] == $past(movxReq.lowAddr))
    else $error("page register not used as high byte");

  chk_split_onchip: assert property (
    acc8 && splitNow && !page[4] |=> !memExt && effAddr[11:8] == $past(page[3:0]))
    else $error("split mode on-chip page wrong");

  chk_split_offchip: assert property (
    acc8 && splitNow && page[4] |=> memExt && ale)
    else $error("split mode page top bit did not go off-chip");

  chk_offchip_page: assert property (
    acc8 && splitNow && page[4]
    |=> effAddr == {4'h0, $past(page[3:0]), $past(movxReq.lowAddr)})
    else $error("off-chip page address wrong");

  chk_nobank_float: assert property (
    acc8 && mode == EMP_MODE_SPLIT_NB && page[4] |=> !addrHiOe)
    else $error("upper lines driven without bank select");

  chk_bank_drive: assert property (
    acc8 && mode == EMP_MODE_SPLIT_BS && page[4]
    |=> addrHiOe && addrHi == $past(page[3:0]) && addrLo == $past(movxReq.lowAddr))
    else $error("bank select upper lines wrong");

  chk_ext_ignore: assert property (
    acc8 && mode == EMP_MODE_EXTERNAL |=> memExt && !addrHiOe && effAddr[15:8] == 8'h00)
    else $error("external mode used page register");

  chk_ale_min: assert property (
    $rose(ale) && curWidth == 2'h0 |=> !ale ##1 !ale && movxDone)
    else $error("latch enable width one cycle wrong");

  chk_ale_max: assert property (
    $rose(ale) && curWidth == 2'h3 |-> ale[*4] ##1 !ale[*4])
    else $error("latch enable width four cycles wrong");

  chk_mode_frozen: assert property (
    busy && $past(busy) |-> $stable(curMode) && $stable(effAddr) && $stable(curWidth))
    else $error("settings changed during a move");

  cov_bank_move: cover property (acc8 && mode == EMP_MODE_SPLIT_BS && page[4] ##[1:20] movxDone);
  cov_ext_move:  cover property (accept && mode == EMP_MODE_EXTERNAL ##[1:20] movxDone);
  cov_mid_write: cover property (busy && sfrWrEn && sfrAddr == `EMP_CFG_ADDR);

endmodule

`default_nettype wire

// ==== sim/emp_sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module emp_sram_model #(
  parameter logic [3:0] PORT_HI = 4'hA // Level the port latches hold on A11..A8
) (
  input  wire logic        sys_clk,  // System clock
  input  wire logic        ale,      // Address latch enable
  input  wire logic [3:0]  addrHi,   // A11..A8 when driven
  input  wire logic        addrHiOe, // A11..A8 driven
  input  wire logic [7:0]  addrLo,   // A7..A0
  output logic      [11:0] latched   // Address held by the memory
);
  // Latch follows the bus while ale is high; undriven upper lines show the port latches
  always_ff @(posedge sys_clk) begin
    if (ale) begin
      latched <= {addrHiOe ? addrHi : PORT_HI, addrLo};
    end
  end
endmodule

`default_nettype wire

// ==== sim/external_memory_page_mode_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module external_memory_page_mode_config_bench;
  import emp_pkg::*;
  logic        sys_clk   = 1'h0;
  logic        srst      = 1'h1;
  logic        sfrWrEn   = 1'h0;
  logic        sfrRdEn   = 1'h0;
  logic        movxStart = 1'h0;
  logic [7:0]  sfrAddr   = 8'h00;
  logic [7:0]  sfrWrData = 8'h00;
  emp_req_t    movxReq   = '0;
  logic [7:0]  sfrRdData;
  logic        busy, movxDone, memExt, memWrite, ale, addrHiOe, ext, oe, mw;
  logic [7:0]  addrLo;
  logic [15:0] effAddr, ea;
  logic [3:0]  addrHi;
  logic [11:0] latched;
  int          badCount  = 0;
  int          nCompared = 0;
  int          hiC, loC;

  // Free-running system clock, 50 ns period
  always #25 sys_clk = ~sys_clk;

  emp_page_config emp_page_config_i (.sys_clk, .srst, .sfrWrEn, .sfrRdEn, .sfrAddr,
    .sfrWrData, .sfrRdData, .movxStart, .movxReq, .busy, .movxDone, .memExt, .memWrite,
    .effAddr, .addrHi, .addrHiOe, .addrLo, .ale);
  emp_sram_model emp_sram_model_i (.sys_clk, .ale, .addrHi, .addrHiOe,
    .addrLo, .latched);

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfrWrEn <= 1'h1;
    sfrAddr <= a;
    sfrWrData <= d;
    @(posedge sys_clk);
    sfrWrEn <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfrRdEn <= 1'h1;
    sfrAddr <= a;
    @(posedge sys_clk);
    sfrRdEn <= 1'h0;
    #1 cmp("sfrRdData", {8'h00, exp}, {8'h00, sfrRdData});
  endtask

  // One move; counts ale high and low cycles until the done pulse
  task automatic xfer(input emp_req_t rq);
    int k;
    @(posedge sys_clk);
    movxStart <= 1'h1;
    movxReq <= rq;
    @(posedge sys_clk);
    movxStart <= 1'h0;
    #1;
    ext = memExt;
    oe = addrHiOe;
    ea = effAddr;
    mw = memWrite;
    cmp("busy", 16'h0001, {15'h0000, busy});
    hiC = 0;
    loC = 0;
    for (k = 0; k < 40 && movxDone !== 1'h1; k++) begin
      if (ale) hiC++;
      else if (hiC > 0) loC++;
      @(posedge sys_clk);
      #1;
    end
    cmp("movxDone", 16'h0001, {15'h0000, movxDone});
  endtask

  // 8-bit indirect read with the given index value
  task automatic move(input logic [7:0] lo);
    xfer(emp_req_t'{1'h1, 1'h0, lo, 16'h0000});
  endtask

  task automatic route(input logic [1:0] md, input logic [7:0] pg, input logic [7:0] lo,
                       input logic xe, input logic xo, input logic [15:0] xa,
                       input logic [11:0] xl);
    wr(8'hAB, {4'h0, md, 2'h0});
    wr(8'hAA, pg);
    move(lo);
    cmp("memExt", {15'h0000, xe}, {15'h0000, ext});
    cmp("addrHiOe", {15'h0000, xo}, {15'h0000, oe});
    cmp("effAddr", xa, ea);
    if (xe) cmp("latched", {4'h0, xl}, {4'h0, latched});
  endtask

  task automatic test_regs;
    rd(8'hAA, 8'h00);
    rd(8'hAB, 8'h03);
    wr(8'hAA, 8'hFF);
    rd(8'hAA, 8'h1F);
    wr(8'hAB, 8'hFF);
    rd(8'hAB, 8'h0F);
    rd(8'hAC, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_routing;
    route(2'h0, 8'h0F, 8'h34, 1'h0, 1'h0, 16'h0F34, 12'h000);
    route(2'h0, 8'h1F, 8'h34, 1'h0, 1'h0, 16'h0F34, 12'h000);
    route(2'h1, 8'h11, 8'h22, 1'h1, 1'h0, 16'h0122, 12'hA22);
    route(2'h1, 8'h05, 8'h22, 1'h0, 1'h0, 16'h0522, 12'h000);
    route(2'h2, 8'h11, 8'h22, 1'h1, 1'h1, 16'h0122, 12'h122);
    route(2'h3, 8'h11, 8'h22, 1'h1, 1'h0, 16'h0022, 12'hA22);
    $display("test routing done");
  endtask

  // Every width code; high and low phases must each last code plus one cycles
  task automatic test_ale;
    for (int w = 0; w < 4; w++) begin
      wr(8'hAB, {4'h0, 2'h3, 2'(w)});
      move(8'h10);
      cmp("aleHigh", 16'(w + 1), 16'(hiC));
      cmp("aleLow", 16'(w + 1), 16'(loC));
    end
    $display("test ale done");
  endtask

  // Page and config writes in mid-move must not disturb it, only the following move
  task automatic test_midwrite;
    wr(8'hAB, 8'h0B);
    wr(8'hAA, 8'h11);
    fork
      move(8'h22);
      begin
        repeat (3) @(posedge sys_clk);
        wr(8'hAA, 8'h12);
        wr(8'hAB, 8'h08);
      end
    join
    cmp("aleHigh", 16'h0004, 16'(hiC));
    cmp("aleLow", 16'h0004, 16'(loC));
    cmp("effAddr", 16'h0122, effAddr);
    cmp("latched", 16'h0122, {4'h0, latched});
    move(8'h22);
    cmp("effAddr", 16'h0222, ea);
    cmp("addrHiOe", 16'h0001, {15'h0000, oe});
    cmp("latched", 16'h0222, {4'h0, latched});
    cmp("aleHigh", 16'h0001, 16'(hiC));
    cmp("aleLow", 16'h0001, 16'(loC));
    $display("test midwrite done");
  endtask

  // 16-bit moves: in split mode the pointer picks the target, off-chip drives all twelve lines
  task automatic test_wide;
    wr(8'hAB, 8'h00);
    xfer(emp_req_t'{1'h0, 1'h1, 8'h00, 16'h1234});
    cmp("memExt", 16'h0000, {15'h0000, ext});
    cmp("effAddr", 16'h0234, ea);
    cmp("memWrite", 16'h0001, {15'h0000, mw});
    wr(8'hAB, 8'h04);
    xfer(emp_req_t'{1'h0, 1'h0, 8'h00, 16'h1234});
    cmp("memExt", 16'h0001, {15'h0000, ext});
    cmp("effAddr", 16'h1234, ea);
    cmp("addrHiOe", 16'h0001, {15'h0000, oe});
    cmp("latched", 16'h0234, {4'h0, latched});
    cmp("memWrite", 16'h0000, {15'h0000, mw});
    wr(8'hAB, 8'h0C);
    xfer(emp_req_t'{1'h0, 1'h0, 8'h00, 16'h0034});
    cmp("memExt", 16'h0001, {15'h0000, ext});
    cmp("effAddr", 16'h0034, ea);
    $display("test wide done");
  endtask

  // A reset in mid-run returns both registers to their reset values
  task automatic test_reset;
    wr(8'hAA, 8'h15);
    @(posedge sys_clk);
    srst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    rd(8'hAA, 8'h00);
    rd(8'hAB, 8'h03);
    $display("test reset done");
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'h0;
    test_regs();
    test_routing();
    test_ale();
    test_midwrite();
    test_wide();
    test_reset();
    tally_and_finish();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    badCount++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
